// file: cfd_pkg.sv
// shared constants, state and mode codes of the console-file diagnostic sequencer
package cfd_pkg;

    // machine cycle timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MACH_CYCLE_NS = 200;
    localparam int CYCLE_CLKS = (MACH_CYCLE_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;

    // console-file command codes
    localparam logic [7:0] CMD_LOAD_EXEC = 8'h70;
    localparam logic [7:0] CMD_CMP_BASE = 8'h78;
    localparam logic [7:0] CMD_CMP_MASK = 8'hF8;
    localparam logic [7:0] CMD_LS_BASE = 8'hC0;
    localparam logic [7:0] CMD_LS_MASK = 8'hC0;

    // microaddress byte 3: bits 3..5 counted from the msb
    localparam int CMP_LO = 2;
    localparam int CMP_W = 3;

    // local storage
    localparam int LS_ADDR_W = 6;
    localparam int WORD_W = 32;

    // track/sector byte: track in the upper five bits, sector below
    localparam int TS_TRACK_LO = 3;
    localparam int TS_TRACK_W = 5;
    localparam int TS_SECTOR_W = 3;

    // operator mode switch
    localparam logic [1:0] MODE_FILE = 2'h0;
    localparam logic [1:0] MODE_SWITCH = 2'h1;
    localparam logic [1:0] MODE_LOCAL_STORE_AS_CONTROL_MODE = 2'h2;

    // register map
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CLEAR = 8'h04;
    localparam logic [7:0] REG_ENABLE = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam logic [7:0] REG_CWORD = 8'h10;

    // status bits
    localparam int EV_W = 3;
    localparam int EV_DIAG = 0;
    localparam int EV_COUNT = 1;
    localparam int EV_HALT = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_FILE_WAIT = 6'b00_0010,
        ST_FILE_EXEC = 6'b00_0100,
        ST_SW_EXEC = 6'b00_1000,
        ST_LS_EXEC = 6'b01_0000,
        ST_LS_DUMMY = 6'b10_0000
    } cfd_state_type;

endpackage : cfd_pkg

// file: cfd_cycle_timer.sv
// free-running machine cycle timer, one tick per machine cycle
`timescale 1ns/100ps
module cfd_cycle_timer #(
    parameter int CLKS = 25
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // cycle boundary
    output logic tick_out
);
    localparam int CW = (CLKS < 2) ? 1 : $clog2(CLKS);
    localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

    logic [CW-1:0] cnt_ff;

    generate
        if (CLKS < 2) begin : g_bad
            $error("cfd_cycle_timer needs at least two clocks per cycle");
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
            tick_out <= 1'b0;
        end else if (cnt_ff == LAST) begin
            cnt_ff <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule : cfd_cycle_timer

// file: cfd_local_store.sv
// flip-flop local storage, one write port and one read port
`timescale 1ns/100ps
module cfd_local_store #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    // read port, combinational
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    localparam int DEPTH = 1 << AW;

    logic [DW-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (wr_en_in) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = mem_ff[rd_addr_in];

endmodule : cfd_local_store

// file: cfd_diag_sequencer.sv
// console-file diagnostic sequencer top
//
// Overview of operation
// - basic tests load the control word register from the file, one word per command.
// - an error detected in an execute or dummy cycle turns on the diagnostic stop indicator; one during a file wait is ignored.
// - command 70 loads the control word from the file data and executes it.
// - command 7F loads and executes, then compares microaddress byte 3 bits 3-5.
// - a compare mismatch sets diagnostic stop and ends file execution.
// - file execution stops after the word whose byte position equals the count.
// - the track/sector byte holds track in bits 0-4 and sector in bits 5-7.
// - the execute-switch position executes the control word in switches A-H.
// - for local-store mode, file commands C0-FF of an earlier file run write file words into A local storage.
// - in that mode each word is fetched from local storage, loaded and executed.
// - in that mode one dummy cycle follows every word executed without error.
// - the dummy cycle lets a local-storage destination write finish first.
// - every machine cycle, dummy ones included, lasts about 200 ns.
`timescale 1ns/100ps
module cfd_diag_sequencer
    import cfd_pkg::*;
#(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS,
    parameter int LS_AW = LS_ADDR_W
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // operator controls
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic [1:0] mode_sel_in,
    input wire logic [7:0] byte_count_value_in,
    input wire logic [WORD_W-1:0] switch_word_in,
    // console file drive
    input wire logic file_cmd_valid_in,
    input wire logic [7:0] file_cmd_code_in,
    input wire logic [WORD_W-1:0] file_data_in,
    input wire logic [7:0] file_byte_pos_in,
    input wire logic [TS_TRACK_W-1:0] file_track_in,
    input wire logic [TS_SECTOR_W-1:0] file_sector_in,
    output logic file_cmd_ack_out,
    // processor side
    input wire logic [7:0] maddr_byte3_in,
    input wire logic cpu_error_in,
    input wire logic cpu_ls_wr_in,
    input wire logic [LS_AW-1:0] cpu_ls_addr_in,
    input wire logic [WORD_W-1:0] cpu_ls_data_in,
    output logic [WORD_W-1:0] cw_out,
    output logic exec_pulse_out,
    output logic dummy_cycle_out,
    output logic local_store_as_control_mode_mode_out,
    output logic diag_stop_out,
    output logic [7:0] ts_byte_out,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out
);
    generate
        if (LS_AW < 1 || LS_AW > 8 || CYCLE_CLKS_P > 256) begin : g_bad
            $error("cfd_diag_sequencer parameter out of range");
        end
    endgenerate

    cfd_state_type state_ff;
    cfd_state_type nxt_state;
    logic tick;
    logic start_req_ff;
    logic stop_req_ff;
    logic cmp_pend_ff;
    logic [CMP_W-1:0] expect_ff;
    logic [7:0] pos_ff;
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] nxt_status;
    logic [EV_W-1:0] enable_ff;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] clr_bits;
    logic take_cmd;
    logic is_exec;
    logic is_cmp;
    logic is_ls;
    logic mismatch;
    logic count_hit;
    logic running;
    logic launch;
    logic ls_wr_en;
    logic [LS_AW-1:0] ls_wr_addr;
    logic [WORD_W-1:0] ls_wr_data;
    logic [LS_AW-1:0] ls_rd_addr;
    logic [WORD_W-1:0] ls_rd_data;

    cfd_cycle_timer #(
        .CLKS(CYCLE_CLKS_P)
    ) u_timer (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .tick_out(tick)
    );

    // file words and processor destination writes share the one port;
    // they never meet since file loading stops before local-store mode
    always_comb begin
        ls_wr_en = 1'b0;
        ls_wr_addr = cpu_ls_addr_in;
        ls_wr_data = cpu_ls_data_in;
        if (take_cmd && is_ls) begin
            ls_wr_en = 1'b1;
            ls_wr_addr = file_cmd_code_in[LS_AW-1:0];
            ls_wr_data = file_data_in;
        end else if (local_store_as_control_mode_mode_out && cpu_ls_wr_in) begin
            ls_wr_en = 1'b1;
        end
    end

    // the next microaddress selects the local-store word to fetch
    assign ls_rd_addr = maddr_byte3_in[7 -: LS_AW];

    cfd_local_store #(
        .AW(LS_AW),
        .DW(WORD_W)
    ) u_lstore (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .wr_en_in(ls_wr_en),
        .wr_addr_in(ls_wr_addr),
        .wr_data_in(ls_wr_data),
        .rd_addr_in(ls_rd_addr),
        .rd_data_out(ls_rd_data)
    );

    // command decode and run conditions
    always_comb begin
        is_exec = file_cmd_code_in == CMD_LOAD_EXEC;
        is_cmp = (file_cmd_code_in & CMD_CMP_MASK) == CMD_CMP_BASE;
        is_ls = (file_cmd_code_in & CMD_LS_MASK) == CMD_LS_BASE;
        // a pending stop wins, so no command is acked on the way out
        take_cmd = (state_ff == ST_FILE_WAIT) && tick && file_cmd_valid_in &&
            !stop_req_ff;
        mismatch = cmp_pend_ff &&
            (maddr_byte3_in[CMP_LO +: CMP_W] != expect_ff);
        count_hit = pos_ff == byte_count_value_in;
        running = state_ff != ST_IDLE;
        launch = (state_ff == ST_IDLE) && tick && start_req_ff;
    end

    // sequencing: every move happens on a machine-cycle boundary
    always_comb begin
        nxt_state = state_ff;
        events = EV_RESET;
        unique case (state_ff)
            ST_IDLE: begin
                if (launch) begin
                    unique case (mode_sel_in)
                        MODE_SWITCH: nxt_state = ST_SW_EXEC;
                        MODE_LOCAL_STORE_AS_CONTROL_MODE: nxt_state = ST_LS_EXEC;
                        default: nxt_state = ST_FILE_WAIT;
                    endcase
                end
            end
            ST_FILE_WAIT: begin
                if (tick && stop_req_ff) begin
                    nxt_state = ST_IDLE;
                    events[EV_HALT] = 1'b1;
                end else if (take_cmd) begin
                    if (is_exec || is_cmp) begin
                        nxt_state = ST_FILE_EXEC;
                    end else if (file_byte_pos_in == byte_count_value_in) begin
                        nxt_state = ST_IDLE;
                        events[EV_COUNT] = 1'b1;
                    end
                end
            end
            ST_FILE_EXEC: begin
                if (tick) begin
                    if (cpu_error_in || mismatch) begin
                        nxt_state = ST_IDLE;
                        events[EV_DIAG] = 1'b1;
                    end else if (count_hit) begin
                        nxt_state = ST_IDLE;
                        events[EV_COUNT] = 1'b1;
                    end else begin
                        nxt_state = ST_FILE_WAIT;
                    end
                end
            end
            ST_SW_EXEC: begin
                if (tick) begin
                    nxt_state = ST_IDLE;
                    events[EV_DIAG] = cpu_error_in;
                    events[EV_HALT] = !cpu_error_in;
                end
            end
            ST_LS_EXEC: begin
                if (tick) begin
                    if (cpu_error_in) begin
                        nxt_state = ST_IDLE;
                        events[EV_DIAG] = 1'b1;
                    end else begin
                        nxt_state = ST_LS_DUMMY;
                    end
                end
            end
            ST_LS_DUMMY: begin
                if (tick) begin
                    if (cpu_error_in) begin
                        nxt_state = ST_IDLE;
                        events[EV_DIAG] = 1'b1;
                    end else if (stop_req_ff) begin
                        nxt_state = ST_IDLE;
                        events[EV_HALT] = 1'b1;
                    end else begin
                        nxt_state = ST_LS_EXEC;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= ST_IDLE;
            dummy_cycle_out <= 1'b0;
            local_store_as_control_mode_mode_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            dummy_cycle_out <= nxt_state == ST_LS_DUMMY;
            local_store_as_control_mode_mode_out <= (nxt_state == ST_LS_EXEC) ||
                             (nxt_state == ST_LS_DUMMY);
        end
    end

    // start and stop pushes wait for the next cycle boundary
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            start_req_ff <= 1'b0;
            stop_req_ff <= 1'b0;
        end else begin
            if (start_in && !running) begin
                start_req_ff <= 1'b1;
            end else if (launch || running) begin
                start_req_ff <= 1'b0;
            end
            if (stop_in && running) begin
                stop_req_ff <= 1'b1;
            end else if (!running) begin
                stop_req_ff <= 1'b0;
            end
        end
    end

    // control word register and execute strobe
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cw_out <= '0;
            exec_pulse_out <= 1'b0;
        end else begin
            exec_pulse_out <= 1'b0;
            if (take_cmd && (is_exec || is_cmp)) begin
                cw_out <= file_data_in;
                exec_pulse_out <= 1'b1;
            end else if (launch && mode_sel_in == MODE_SWITCH) begin
                cw_out <= switch_word_in;
                exec_pulse_out <= 1'b1;
            end else if (nxt_state == ST_LS_EXEC && state_ff != ST_LS_EXEC) begin
                cw_out <= ls_rd_data;
                exec_pulse_out <= 1'b1;
            end
        end
    end

    // compare expectation, byte position and track/sector display
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmp_pend_ff <= 1'b0;
            expect_ff <= '0;
            pos_ff <= 8'h00;
            ts_byte_out <= 8'h00;
            file_cmd_ack_out <= 1'b0;
        end else begin
            file_cmd_ack_out <= take_cmd;
            if (take_cmd) begin
                cmp_pend_ff <= is_cmp;
                expect_ff <= file_cmd_code_in[CMP_W-1:0];
                pos_ff <= file_byte_pos_in;
                ts_byte_out <= {file_track_in, file_sector_in};
            end
        end
    end

    // diagnostic stop light stays on until the next start
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            diag_stop_out <= 1'b0;
        end else if (events[EV_DIAG]) begin
            diag_stop_out <= 1'b1;
        end else if (launch) begin
            diag_stop_out <= 1'b0;
        end
    end

    // sticky status, set wins over a clear in the same cycle
    always_comb begin
        clr_bits = '0;
        if (reg_wr_in && reg_addr_in == REG_CLEAR) begin
            clr_bits = reg_wdata_in[EV_W-1:0];
        end
        nxt_status = (status_ff & ~clr_bits) | events;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_ff <= EV_RESET;
            enable_ff <= EV_RESET;
            irq_out <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (reg_wr_in && reg_addr_in == REG_ENABLE) begin
                enable_ff <= reg_wdata_in[EV_W-1:0];
            end
            irq_out <= |(nxt_status & enable_ff);
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_STATUS: reg_rdata_out <= {29'h0000_0000, status_ff};
                REG_ENABLE: reg_rdata_out <= {29'h0000_0000, enable_ff};
                REG_STATE: reg_rdata_out <= {2'h0, state_ff, 8'h00,
                                             ts_byte_out, pos_ff};
                REG_CWORD: reg_rdata_out <= cw_out;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // helper: clocks since the last cycle tick
    logic [7:0] gap_ff;
    logic seen_tick_ff;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap_ff <= 8'h00;
            seen_tick_ff <= 1'b0;
        end else if (tick) begin
            gap_ff <= 8'h00;
            seen_tick_ff <= 1'b1;
        end else begin
            gap_ff <= gap_ff + 8'h01;
        end
    end

    chk_cycle_length: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (tick && seen_tick_ff) |-> gap_ff == 8'(CYCLE_CLKS_P - 1))
        else $error("machine cycle length wrong");

    chk_file_load_exec: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (take_cmd && is_exec) |=>
            (cw_out == $past(file_data_in)) && exec_pulse_out &&
            state_ff == ST_FILE_EXEC)
        else $error("file word not loaded and executed");

    chk_cmp_mismatch: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ST_FILE_EXEC && tick && mismatch) |=>
            diag_stop_out && state_ff == ST_IDLE && !exec_pulse_out)
        else $error("mismatch did not stop the run");

    chk_cmp_match_go: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ST_FILE_EXEC && tick && cmp_pend_ff && !mismatch &&
         !cpu_error_in && !count_hit) |=> state_ff == ST_FILE_WAIT)
        else $error("matching compare stopped the run");

    chk_count_stop: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ST_FILE_EXEC && tick && !mismatch && !cpu_error_in &&
         count_hit) |=> state_ff == ST_IDLE && status_ff[EV_COUNT])
        else $error("byte count did not stop the run");

    chk_error_stop: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (running && state_ff != ST_FILE_WAIT && tick && cpu_error_in) |=>
            diag_stop_out ##1 diag_stop_out)
        else $error("error did not light diagnostic stop");

    chk_switch_exec: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (launch && mode_sel_in == MODE_SWITCH) |=>
            cw_out == $past(switch_word_in) && exec_pulse_out)
        else $error("switch word not executed");

    chk_dummy_after: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ST_LS_EXEC && tick && !cpu_error_in) |=>
            (dummy_cycle_out && !exec_pulse_out) ##[1:256]
            (tick && dummy_cycle_out))
        else $error("dummy cycle missing after word");

    chk_ls_fetch: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (state_ff == ST_LS_DUMMY && tick && !cpu_error_in && !stop_req_ff)
        |=> cw_out == $past(ls_rd_data) && exec_pulse_out && local_store_as_control_mode_mode_out)
        else $error("local-store word not fetched");

    chk_ts_encode: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        take_cmd |=> ts_byte_out[7 -: TS_TRACK_W] == $past(file_track_in) &&
            ts_byte_out[TS_TRACK_LO-1:0] == $past(file_sector_in))
        else $error("track/sector byte misencoded");

endmodule : cfd_diag_sequencer

// file: cfd_drive_model.sv
// console file drive model: offers queued commands one at a time
`timescale 1ns/100ps
module cfd_drive_model (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // command handshake
    input wire logic ack_in,
    output logic valid_out,
    output logic [7:0] code_out,
    output logic [31:0] data_out,
    output logic [7:0] pos_out
);
    logic [47:0] cmd_q[$];

    task automatic push(input logic [47:0] c);
        cmd_q.push_back(c);
    endtask : push

    // a command stands until acknowledged; a released bus toggles so that
    // nothing downstream can lean on a stale word
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {valid_out, code_out, data_out, pos_out} <= '0;
        end else if (ack_in || !valid_out) begin
            if (cmd_q.size() > 0) begin
                {code_out, data_out, pos_out} <= cmd_q.pop_front();
                valid_out <= 1'b1;
            end else begin
                {code_out, data_out, pos_out} <= ~{code_out, data_out, pos_out};
                valid_out <= 1'b0;
            end
        end
    end
endmodule : cfd_drive_model

// file: test_console_file_diag_sequencer.sv
// self-checking testbench of the console-file diagnostic sequencer
`timescale 1ns/100ps
module test_console_file_diag_sequencer;
    import cfd_pkg::*;
    localparam int CYC = 4;
    logic clk_sys_in = 0, resetn_in = 0, start_in = 0, stop_in = 0;
    logic [1:0] mode_sel_in = MODE_FILE;
    logic [7:0] cnt = 0, maddr = 0, reg_addr_in = 0, code, pos, ts;
    logic cpu_err = 0, reg_wr_in = 0, reg_rd_in = 0, rd_d = 0;
    logic valid, ack, exec, dummy, local_store_as_control_mode, dstop, irq;
    logic [2:0] en = 3'h7;
    logic ls_wr = 0;
    logic [4:0] trk = 5'h01;
    logic [2:0] sec = 3'h2;
    logic [31:0] ls_wd = 0;
    logic [31:0] sw_word = 0, reg_wdata_in = 0, ls_exp = 'x, lsw, d = 0;
    logic [31:0] fdata, cw, rdata;
    logic [31:0] cw_q[$], rv_q[$], rm_q[$];
    int n_mismatch = 0, n_compared = 0;

    always #4 clk_sys_in = ~clk_sys_in;

    cfd_diag_sequencer #(.CYCLE_CLKS_P(CYC)) DUT (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .start_in(start_in), .stop_in(stop_in), .mode_sel_in(mode_sel_in),
        .byte_count_value_in(cnt), .switch_word_in(sw_word),
        .file_cmd_valid_in(valid), .file_cmd_code_in(code),
        .file_data_in(fdata), .file_byte_pos_in(pos),
        .file_track_in(trk), .file_sector_in(sec),
        .file_cmd_ack_out(ack), .maddr_byte3_in(maddr),
        .cpu_error_in(cpu_err), .cpu_ls_wr_in(ls_wr),
        .cpu_ls_addr_in(maddr[7:2]), .cpu_ls_data_in(ls_wd),
        .cw_out(cw), .exec_pulse_out(exec), .dummy_cycle_out(dummy),
        .local_store_as_control_mode_mode_out(local_store_as_control_mode), .diag_stop_out(dstop), .ts_byte_out(ts),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata), .irq_out(irq));

    cfd_drive_model drv (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ack_in(ack),
        .valid_out(valid), .code_out(code), .data_out(fdata),
        .pos_out(pos));

    task automatic chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys_in) begin
        rd_d <= reg_rd_in;
        if (rd_d && rm_q.size() > 0) begin
            if (rm_q[0] != 0) chk(rdata & rm_q[0], rv_q[0]);
            void'(rm_q.pop_front());
            void'(rv_q.pop_front());
        end
        if (exec) chk(cw, cw_q.size() > 0 ? cw_q.pop_front() : ls_exp);
        if (dummy) chk(exec, 0);
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, v);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        rm_q.push_back(m);
        rv_q.push_back(v);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        d = rdata;
    endtask : rd

    task automatic fcmd(input logic [7:0] c, p, input logic x);
        d = $urandom;
        drv.push({c, d, p});
        if (x) cw_q.push_back(d);
    endtask : fcmd

    // settings change only between runs
    task automatic run(input logic [1:0] m, input logic [7:0] c,
                       input logic [2:0] st);
        int n;
        @(posedge clk_sys_in);
        mode_sel_in <= m;
        cnt <= c;
        @(posedge clk_sys_in);
        start_in <= 1'b1;
        @(posedge clk_sys_in);
        start_in <= 1'b0;
        if (m == MODE_LOCAL_STORE_AS_CONTROL_MODE) begin
            n = 0;
            repeat (200) begin
                @(posedge clk_sys_in);
                #1 if (dummy) n++;
                else if (n > 0) break;
            end
            chk(n, CYC);
            chk(local_store_as_control_mode, 1);
            // a destination write in the next dummy must reach the fetch
            repeat (CYC + 1) @(posedge clk_sys_in);
            ls_wr <= 1'b1;
            ls_wd <= ~ls_exp;
            @(posedge clk_sys_in);
            ls_wr <= 1'b0;
            ls_exp = ~ls_exp;
            @(posedge clk_sys_in);
            stop_in <= 1'b1;
            @(posedge clk_sys_in);
            stop_in <= 1'b0;
        end
        d = 0;
        for (int i = 0; i < 400 && (d & st) == 0; i++) rd(REG_STATUS, 0, 0);
        rd(REG_STATUS, {29'h0, st}, {29'h0, st});
        chk(irq, |(st & en));
        chk(dstop, st[0]);
        wr(REG_CLEAR, 32'h0000_0007);
        rd(REG_STATUS, '1, 0);
        chk(irq, 0);
        $display("test run mode %0d status %0h done", m, st);
    endtask : run

    initial begin
        void'($urandom(32'h4420));
        repeat (12) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rd(REG_STATUS, '1, 0);
        rd(REG_STATE, '1, 32'h0100_0000);
        rd(8'h20, '1, 0);
        wr(REG_ENABLE, 32'h0000_0007);
        rd(REG_ENABLE, '1, 32'h0000_0007);
        for (int k = 0; k < 8; k++) begin
            maddr <= {3'h0, 3'(k), 2'h0};
            fcmd(CMD_CMP_BASE + 8'(k), 8'(k), 1);
            run((k == 7) ? 2'h3 : MODE_FILE, 8'(k), 3'h2);
        end
        chk(ts, 8'h0A);
        rd(REG_STATE, 32'h0000_FF00, 32'h0000_0A00);
        maddr <= 8'h1C;
        fcmd(CMD_LOAD_EXEC, 8'h01, 1);
        fcmd(8'h7F, 8'h06, 1);
        fcmd(CMD_LOAD_EXEC, 8'h0B, 1);
        fcmd(CMD_LOAD_EXEC, 8'h10, 0);
        run(MODE_FILE, 8'h0B, 3'h2);
        cw_q.push_back(fdata);
        run(MODE_FILE, 8'h10, 3'h2);
        fcmd(8'h7B, 8'h15, 1);
        fcmd(CMD_LOAD_EXEC, 8'h1A, 0);
        run(MODE_FILE, 8'h1A, 3'h1);
        cpu_err <= 1'b1;
        cw_q.push_back(fdata);
        run(MODE_FILE, 8'h1A, 3'h1);
        cpu_err <= 1'b0;
        d = $urandom;
        sw_word <= d;
        cw_q.push_back(d);
        en = 3'h3;
        wr(REG_ENABLE, 32'h0000_0003);
        run(MODE_SWITCH, 8'h00, 3'h4);
        rd(REG_CWORD, '1, sw_word);
        en = 3'h7;
        wr(REG_ENABLE, 32'h0000_0007);
        fcmd(8'hC5, 8'h1F, 0);
        lsw = d;
        {trk, sec} <= 8'($urandom);
        run(MODE_FILE, 8'h1F, 3'h2);
        chk(ts, {trk, sec});
        maddr <= 8'h14;
        ls_exp = lsw;
        run(MODE_LOCAL_STORE_AS_CONTROL_MODE, 8'h00, 3'h4);
        ls_exp = 'x;
        chk(local_store_as_control_mode, 0);
        chk(cw_q.size(), 0);
        end_of_test();
    end

    initial begin
        #400_000;
        n_mismatch++;
        end_of_test();
    end
endmodule : test_console_file_diag_sequencer
